// [hw/srd_bank.sv]
// One bank state tracker: idle, active with open row, precharging
`timescale 1ns/1ns
`include "srd_map.svh"
module srd_bank
  import srd_pkg::*;
#(
  parameter logic [1:0] BANK_ID = 2'h0,
  parameter int ROW_W = `SRD_ROW_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  srd_cmd_if.dst cmd_in,
  output logic active_o,
  output logic [ROW_W-1:0] row_o
);
  srd_bank_state_type state_q;
  logic [`SRD_PRE_CYCLES_W-1:0] pre_cnt_q;
  logic hit;

  assign hit = cmd_in.valid && cmd_in.tick &&
    (cmd_in.bank == BANK_ID || (cmd_in.cmd == SRD_CMD_CLOSE && cmd_in.all_banks));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= SRD_IDLE;
      pre_cnt_q <= '0;
    end else if (cmd_in.tick) begin
      case (state_q)
        SRD_IDLE: begin
          if (hit && cmd_in.cmd == SRD_CMD_OPEN) begin
            state_q <= SRD_ACTIVE;
          end
        end
        SRD_ACTIVE: begin
          if (hit && cmd_in.cmd == SRD_CMD_CLOSE) begin
            state_q <= SRD_PRECHARGING;
            pre_cnt_q <= `SRD_PRE_CYCLES;
          end
        end
        SRD_PRECHARGING: begin
          if (pre_cnt_q <= 4'h1) begin
            state_q <= SRD_IDLE;
          end
          pre_cnt_q <= pre_cnt_q - 4'h1;
        end
        default: state_q <= SRD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      row_o <= '0;
    end else if (state_q == SRD_IDLE && hit && cmd_in.cmd == SRD_CMD_OPEN) begin
      row_o <= cmd_in.row;
    end
  end

  assign active_o = (state_q == SRD_ACTIVE);
endmodule : srd_bank

// [hw/srd_decoder.sv]
// Row command decoder for a four-bank synchronous DRAM
`timescale 1ns/1ns
`include "srd_map.svh"
// Functional notes
// - Row strobe, column strobe and write enable are captured together each rising edge.
// - Chip select and row strobe low with column strobe high decode a row command.
// - With write enable high that row command opens the selected bank's presented row if that bank is idle.
// - With write enable low it precharges the bank, which goes idle after precharge.
// - Clock enable sampled low suspends the clock next cycle, freezing the outputs.
module srd_decoder
  import srd_pkg::*;
#(
  parameter int ROW_W = `SRD_ROW_W
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic chip_sel_n_i,
  input wire logic row_strobe_n_i,
  input wire logic col_strobe_n_i,
  input wire logic write_en_n_i,
  input wire logic bank_select_lsb_i,
  input wire logic bank_select_msb_i,
  input wire logic [ROW_W-1:0] addr_i,
  output logic [`SRD_NUM_BANKS-1:0] bank_active_o,
  output logic [`SRD_NUM_BANKS*ROW_W-1:0] open_row_o,
  output logic row_open_command_o,
  output logic precharge_command_o
);
  // ---------------------------------------------------------------
  // Reset and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [6+ROW_W:0] pin_s1_q;
  logic [6+ROW_W:0] pin_s2_q;
  logic cke_prev_q;
  logic tick;
  logic [1:0] bank_select_field;
  logic row_cmd;
  logic [`SRD_NUM_BANKS-1:0] act_w;
  logic [`SRD_NUM_BANKS*ROW_W-1:0] row_w;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // All strobes share one sampling edge so they form one command
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
    end else begin
      pin_s1_q <= {clk_en_i, chip_sel_n_i, row_strobe_n_i, col_strobe_n_i, write_en_n_i,
        bank_select_msb_i, bank_select_lsb_i, addr_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  function automatic logic [1:0] bank_num(input logic msb, input logic lsb);
    bank_num = {msb, lsb};
  endfunction : bank_num

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cke_prev_q <= 1'b1;
    end else begin
      cke_prev_q <= pin_s2_q[6+ROW_W];
    end
  end
  // Internal clock runs only when enable was high the cycle before
  assign tick = cke_prev_q;

  assign bank_select_field = bank_num(pin_s2_q[ROW_W+1], pin_s2_q[ROW_W]);
  assign row_cmd = !pin_s2_q[5+ROW_W] && !pin_s2_q[4+ROW_W] && pin_s2_q[3+ROW_W];

  srd_cmd_if cmd_bus ();
  assign cmd_bus.valid = row_cmd;
  assign cmd_bus.cmd = pin_s2_q[2+ROW_W] ? SRD_CMD_OPEN : SRD_CMD_CLOSE;
  assign cmd_bus.bank = bank_select_field;
  assign cmd_bus.row = pin_s2_q[ROW_W-1:0];
  assign cmd_bus.all_banks = pin_s2_q[`SRD_AUTO_CLOSE_BIT];
  assign cmd_bus.tick = tick;

  // ---------------------------------------------------------------
  // Banks
  // ---------------------------------------------------------------
  generate
    for (genvar b = 0; b < `SRD_NUM_BANKS; b++) begin : g_bank
      srd_bank #(
        .BANK_ID(2'(b)),
        .ROW_W(ROW_W)
      ) u_bank (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .cmd_in(cmd_bus),
        .active_o(act_w[b]),
        .row_o(row_w[b*ROW_W +: ROW_W])
      );
    end
  endgenerate

  // Outputs freeze while the internal clock is suspended
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bank_active_o <= '0;
      open_row_o <= '0;
      row_open_command_o <= 1'b0;
      precharge_command_o <= 1'b0;
    end else if (tick) begin
      bank_active_o <= act_w;
      open_row_o <= row_w;
      row_open_command_o <= row_cmd && pin_s2_q[2+ROW_W];
      precharge_command_o <= row_cmd && !pin_s2_q[2+ROW_W];
    end
  end
endmodule : srd_decoder

// [inc/srd_cmd_if.sv]
// Decoded command carrier between decoder and bank tracker
`timescale 1ns/1ns
interface srd_cmd_if;
  import srd_pkg::*;
  logic valid;
  srd_cmd_type cmd;
  logic [1:0] bank;
  logic [12:0] row;
  logic all_banks;
  logic tick;
  modport src (output valid, output cmd, output bank, output row, output all_banks,
    output tick);
  modport dst (input valid, input cmd, input bank, input row, input all_banks, input tick);
endinterface : srd_cmd_if

// [inc/srd_map.svh]
// Constant map for the row command decoder
`ifndef SRD_MAP_SVH
`define SRD_MAP_SVH
`define SRD_NUM_BANKS 4
`define SRD_BANK_W 2
`define SRD_ROW_W 13
`define SRD_PRE_CYCLES_W 4
`define SRD_PRE_CYCLES 4'h3
`define SRD_AUTO_CLOSE_BIT 10
`define SRD_BANK_IDLE 2'h0
`endif

// [inc/srd_pkg.sv]
// Types for the row command decoder
package srd_pkg;
  typedef enum logic [2:0] {
    SRD_IDLE = 3'b001,
    SRD_ACTIVE = 3'b010,
    SRD_PRECHARGING = 3'b100
  } srd_bank_state_type;
  typedef enum logic [1:0] {
    SRD_CMD_NONE = 2'h0,
    SRD_CMD_OPEN = 2'h1,
    SRD_CMD_CLOSE = 2'h2
  } srd_cmd_type;
endpackage : srd_pkg

// [sim/srd_ctrl_model.sv]
// Controller model driving the command strobes
`timescale 1ns/1ns
module srd_ctrl_model (
  input wire logic sys_clk_i,
  output logic ce_o = 1,
  output logic [3:0] cmd_o = 4'h7,
  output logic [1:0] ba_o = 2'h0,
  output logic [12:0] addr_o = 13'h0
);
  // Code order is cs, ras, cas, we; 4'h7 is a no-op
  task send(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    @(posedge sys_clk_i) #1 cmd_o = c;
    ba_o = b;
    addr_o = a;
    // Held strobes would hide a decoder that samples late
    @(posedge sys_clk_i) #1 cmd_o = 4'h7;
    addr_o = ~a;
  endtask : send
endmodule : srd_ctrl_model

// [sim/srd_decoder_assertions.sv]
// Port checks on the row command decoder
`timescale 1ns/1ns
module srd_decoder_assertions (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic chip_sel_n_i,
  input wire logic row_strobe_n_i,
  input wire logic col_strobe_n_i,
  input wire logic write_en_n_i,
  input wire logic bank_select_lsb_i,
  input wire logic bank_select_msb_i,
  input wire logic [3:0] bank_active_o,
  input wire logic row_open_command_o,
  input wire logic precharge_command_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire row_cmd = !chip_sel_n_i && !row_strobe_n_i && col_strobe_n_i;
  // Pins taken at one edge reach the pulse outputs two edges later
  sequence s_open; $past(row_cmd && write_en_n_i, 3); endsequence
  sequence s_close; $past(row_cmd && !write_en_n_i, 3); endsequence
  a_open_cause: assert property (row_open_command_o |-> s_open)
    else $error("open pulse without open code");
  a_close_cause: assert property (precharge_command_o |-> s_close)
    else $error("precharge pulse without its code");
  a_one_kind: assert property (!(row_open_command_o && precharge_command_o))
    else $error("both command pulses at once");
  a_rise_after_open: assert property ((bank_active_o & ~$past(bank_active_o)) != 4'h0
    |-> $past(row_open_command_o)) else $error("bank opened without pulse");
  a_bank_number: assert property ((bank_active_o & ~$past(bank_active_o)) != 4'h0
    |-> (bank_active_o & ~$past(bank_active_o)) == 4'h1 <<
    $past({bank_select_msb_i, bank_select_lsb_i}, 4)) else $error("wrong bank opened");
  a_freeze_hold: assert property (!clk_en_i [*4] |=> $stable(bank_active_o))
    else $error("bank state moved while suspended");
endmodule : srd_decoder_assertions
bind srd_decoder srd_decoder_assertions i_srd_decoder_assertions (.*);

// [sim/tb_top.sv]
// Self-checking bench for the row command decoder
`timescale 1ns/1ns
module tb_top;
  logic sys_clk_i = 0, rstn_i = 0, ce, po, pc;
  logic [3:0] c, act;
  logic [1:0] ba;
  logic [12:0] ad, r[4];
  logic [51:0] rows;
  logic [1:0] notes[$];
  int errors = 0, total_checks = 0, cyc = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  srd_ctrl_model i_srd_ctrl_model (.sys_clk_i, .ce_o(ce), .cmd_o(c), .ba_o(ba), .addr_o(ad));
  srd_decoder i_srd_decoder (.sys_clk_i, .rstn_i, .clk_en_i(ce), .chip_sel_n_i(c[3]),
    .row_strobe_n_i(c[2]), .col_strobe_n_i(c[1]), .write_en_n_i(c[0]),
    .bank_select_lsb_i(ba[0]), .bank_select_msb_i(ba[1]), .addr_i(ad),
    .bank_active_o(act), .open_row_o(rows), .row_open_command_o(po),
    .precharge_command_o(pc));
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  // Deselected and suspended commands leave no note, so any pulse from them is stray
  always @(negedge sys_clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      errors++;
      close_out;
    end
    if (po === 1'b1 || pc === 1'b1) chk(notes.size() > 0 && notes.pop_front() === {po, pc},
      "pulse");
  end
  initial begin
    void'($urandom(33949));
    repeat (3) @(posedge sys_clk_i);
    #1 rstn_i = 1;
    repeat (3) @(posedge sys_clk_i);
    for (int b = 0; b < 4; b++) begin
      r[b] = 13'($urandom);
      notes.push_back(2'h2);
      i_srd_ctrl_model.send(4'h3, 2'(b), r[b] & 13'h1BFF);
      repeat (6) @(posedge sys_clk_i);
      chk(act[b] === 1'b1 && rows[b*13+:13] === (r[b] & 13'h1BFF), "open");
    end
    // Open to a busy bank still pulses the decode output but leaves the row
    notes.push_back(2'h2);
    i_srd_ctrl_model.send(4'h3, 2'h0, 13'($urandom));
    repeat (6) @(posedge sys_clk_i);
    chk(rows[12:0] === (r[0] & 13'h1BFF), "reopen");
    i_srd_ctrl_model.send(4'hA, 2'h1, 13'h0);
    repeat (8) @(posedge sys_clk_i);
    chk(act === 4'hF, "deselect");
    notes.push_back(2'h1);
    i_srd_ctrl_model.send(4'h2, 2'h1, 13'h0);
    repeat (12) @(posedge sys_clk_i);
    chk(act === 4'hD, "close one");
    $display("open and close tests done");
    #1 i_srd_ctrl_model.ce_o = 0;
    repeat (4) @(posedge sys_clk_i);
    i_srd_ctrl_model.send(4'h2, 2'h2, 13'h0);
    repeat (8) @(posedge sys_clk_i);
    chk(act === 4'hD, "suspend");
    #1 i_srd_ctrl_model.ce_o = 1;
    repeat (8) @(posedge sys_clk_i);
    notes.push_back(2'h1);
    i_srd_ctrl_model.send(4'h2, 2'($urandom), 13'h0400);
    repeat (12) @(posedge sys_clk_i);
    chk(act === 4'h0 && notes.size() == 0, "close all");
    $display("suspend and close all tests done");
    close_out;
  end
endmodule : tb_top
